// *** rtl/add_and_bit_ops_exec.sv ***
// Functional notes
// - Add immediate to accumulator, update all flags
// - Add accumulator and file register, all flags
// - Destination bit picks accumulator or file
// - AND immediate into accumulator, zero flag only
// - AND with file register, zero flag only
// - Clear indexed file bit, flags untouched
// - Set indexed file bit, flags untouched
// - Bit zero skips next instruction, two cycles
// - Bit one skips next instruction, two cycles
// - Port registers read pin levels, not latch
`timescale 1ns/1ps
`default_nettype none

module add_and_bit_ops_exec
    import exec_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire instr_s instr_i,
    input wire logic [DATA_W-1:0] file_rdata_i,
    input wire logic file_is_port_i,
    input wire logic [DATA_W-1:0] pin_levels_i,
    output logic instr_skip_o,
    output logic no_operation_o,
    output logic [DATA_W-1:0] accum_o,
    output flags_s flags_o,
    output logic file_we_o,
    output logic [ADDR_W-1:0] file_waddr_o,
    output logic [DATA_W-1:0] file_wdata_o
);

    exec_state_s q; // Registered state
    exec_state_s d; // Next state
    logic take; // An instruction executes this cycle
    logic [DATA_W-1:0] operand; // File value seen by the operation
    alu_out_s alu; // Operation unit result

    // Pins are asynchronous, so only the synchronised copy feeds logic;
    // the price is that a port value is two cycles old when used
    assign operand = file_is_port_i ? q.pin_sync : file_rdata_i;

    // Instructions offered while discarding are dropped, never executed
    assign take = instr_i.valid && (q.seq == ST_EXEC);

    exec_alu u_alu (
        .op_i(instr_i.op),
        .accum_i(q.accum),
        .operand_i(operand),
        .lit_i(instr_i.lit),
        .bidx_i(instr_i.bidx),
        .out_o(alu)
    );

    // Next-state logic for the whole slice
    always_comb begin
        d = q;
        d.pin_meta = pin_levels_i;
        d.pin_sync = q.pin_meta;
        d.file_we = 1'b0;
        d.no_operation = 1'b0;
        case (q.seq)
            ST_EXEC: begin
                if (take) begin
                    case (instr_i.op)
                        OP_ADD_IMMEDIATE_TO_ACCUM: begin
                            d.accum = alu.result;
                            d.flags = alu.flags;
                        end
                        OP_ADD_ACCUM_WITH_FILE: begin
                            d.flags = alu.flags;
                            if (instr_i.dest == DEST_FILE) begin
                                d.file_we = 1'b1;
                                d.file_waddr = instr_i.faddr;
                                d.file_wdata = alu.result;
                            end else begin
                                d.accum = alu.result;
                            end
                        end
                        OP_AND_IMMEDIATE_WITH_ACCUM: begin
                            d.accum = alu.result;
                            d.flags.zero = alu.flags.zero;
                        end
                        OP_AND_ACCUM_WITH_FILE: begin
                            d.flags.zero = alu.flags.zero;
                            if (instr_i.dest == DEST_FILE) begin
                                d.file_we = 1'b1;
                                d.file_waddr = instr_i.faddr;
                                d.file_wdata = alu.result;
                            end else begin
                                d.accum = alu.result;
                            end
                        end
                        OP_BIT_CLEAR_IN_FILE, OP_BIT_SET_IN_FILE: begin
                            // Read-modify-write, flags kept
                            d.file_we = 1'b1;
                            d.file_waddr = instr_i.faddr;
                            d.file_wdata = alu.result;
                        end
                        OP_TEST_BIT_SKIP_IF_ZERO: begin
                            if (!alu.bit_val) begin
                                d.seq = ST_DISCARD;
                            end
                        end
                        OP_TEST_BIT_SKIP_IF_ONE: begin
                            if (alu.bit_val) begin
                                d.seq = ST_DISCARD;
                            end
                        end
                        default: begin
                            d.seq = ST_EXEC;
                        end
                    endcase
                end
            end
            ST_DISCARD: begin
                // Second cycle of a taken skip runs as an idle slot
                d.no_operation = 1'b1;
                d.seq = ST_EXEC;
            end
            default: begin
                // Recover from an illegal code
                d.seq = ST_EXEC;
            end
        endcase
        if (srst_i) begin
            d.seq = ST_EXEC;
            d.accum = ACCUM_RST;
            d.flags = '0;
            d.file_we = 1'b0;
            d.file_waddr = '0;
            d.file_wdata = ZERO_BYTE;
            d.no_operation = 1'b0;
            d.pin_meta = ZERO_BYTE;
            d.pin_sync = ZERO_BYTE;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        q <= d;
    end

    // Outputs straight from the state
    assign instr_skip_o = (q.seq == ST_DISCARD);
    assign no_operation_o = q.no_operation;
    assign accum_o = q.accum;
    assign flags_o = q.flags;
    assign file_we_o = q.file_we;
    assign file_waddr_o = q.file_waddr;
    assign file_wdata_o = q.file_wdata;

    // Checks on the slice's own behaviour
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    add_imm_a: assert property (
        take && instr_i.op == OP_ADD_IMMEDIATE_TO_ACCUM
        |=> accum_o == DATA_W'($past(q.accum) + $past(instr_i.lit)))
        else $error("add immediate result wrong");

    add_file_a: assert property (
        take && instr_i.op == OP_ADD_ACCUM_WITH_FILE
        && instr_i.dest == DEST_ACCUM
        |=> accum_o == DATA_W'($past(q.accum) + $past(operand)))
        else $error("add file result wrong");

    dest_file_a: assert property (
        take && instr_i.dest == DEST_FILE
        && (instr_i.op == OP_ADD_ACCUM_WITH_FILE
        || instr_i.op == OP_AND_ACCUM_WITH_FILE)
        |=> file_we_o && file_waddr_o == $past(instr_i.faddr)
        && $stable(accum_o))
        else $error("file destination not written");

    and_imm_a: assert property (
        take && instr_i.op == OP_AND_IMMEDIATE_WITH_ACCUM
        |=> accum_o == ($past(q.accum) & $past(instr_i.lit))
        && $stable(flags_o.carry) && $stable(flags_o.half_carry_flag))
        else $error("and immediate wrong");

    and_file_a: assert property (
        take && instr_i.op == OP_AND_ACCUM_WITH_FILE
        |=> $stable(flags_o.carry) && $stable(flags_o.half_carry_flag)
        && flags_o.zero == (($past(q.accum) & $past(operand)) == ZERO_BYTE))
        else $error("and file flags wrong");

    bit_clear_a: assert property (
        take && instr_i.op == OP_BIT_CLEAR_IN_FILE
        |=> file_we_o && !file_wdata_o[$past(instr_i.bidx)]
        && $stable(flags_o) && $stable(accum_o))
        else $error("bit clear wrong");

    bit_set_a: assert property (
        take && instr_i.op == OP_BIT_SET_IN_FILE
        |=> file_we_o && file_wdata_o[$past(instr_i.bidx)]
        && $stable(flags_o))
        else $error("bit set wrong");

    skip_zero_a: assert property (
        take && instr_i.op == OP_TEST_BIT_SKIP_IF_ZERO
        && !operand[instr_i.bidx]
        |=> instr_skip_o && $stable(flags_o) ##1 no_operation_o
        && !instr_skip_o)
        else $error("skip on zero wrong");

    skip_one_a: assert property (
        take && instr_i.op == OP_TEST_BIT_SKIP_IF_ONE
        |=> instr_skip_o == $past(operand[instr_i.bidx]))
        else $error("skip on one wrong");

    pin_read_a: assert property (
        file_is_port_i |-> operand == $past(pin_levels_i, 2))
        else $error("port read not from pins");

    carry_out_a: assert property (
        take && instr_i.op == OP_ADD_IMMEDIATE_TO_ACCUM
        |=> flags_o.carry == ((9'($past(q.accum)) + 9'($past(instr_i.lit)))
        > 9'h0FF) && flags_o.zero == (accum_o == ZERO_BYTE))
        else $error("carry or zero wrong");

endmodule : add_and_bit_ops_exec
`default_nettype wire

// *** shared/exec_pkg.sv ***
package exec_pkg;

    // Datapath geometry
    localparam int DATA_W = 8;   // Accumulator and file register width
    localparam int ADDR_W = 7;   // File register address width
    localparam int BIT_W = 3;    // Bit index width
    localparam int NIBBLE_W = 4; // Half-carry comes out of the low nibble

    // Destination select encoding
    localparam logic DEST_ACCUM = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // Reset and reference values
    localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] ONE_HOT_BIT0 = 8'h01;

    // Operations handled by this execution slice
    typedef enum logic [2:0] {
        OP_ADD_IMMEDIATE_TO_ACCUM = 3'h0,
        OP_ADD_ACCUM_WITH_FILE = 3'h1,
        OP_AND_IMMEDIATE_WITH_ACCUM = 3'h2,
        OP_AND_ACCUM_WITH_FILE = 3'h3,
        OP_BIT_CLEAR_IN_FILE = 3'h4,
        OP_BIT_SET_IN_FILE = 3'h5,
        OP_TEST_BIT_SKIP_IF_ZERO = 3'h6,
        OP_TEST_BIT_SKIP_IF_ONE = 3'h7
    } op_e;

    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_EXEC = 2'h1,
        ST_DISCARD = 2'h2
    } seq_e;

    // Decoded instruction offered by the fetch side
    typedef struct packed {
        logic valid;
        op_e op;
        logic [DATA_W-1:0] lit;
        logic [ADDR_W-1:0] faddr;
        logic dest;
        logic [BIT_W-1:0] bidx;
    } instr_s;

    // Arithmetic status flags
    typedef struct packed {
        logic carry;
        logic half_carry_flag;
        logic zero;
    } flags_s;

    // Combinational result of the operation unit
    typedef struct packed {
        logic [DATA_W-1:0] result;
        flags_s flags;
        logic bit_val;
    } alu_out_s;

    // Whole registered state of the execution slice
    typedef struct packed {
        seq_e seq;
        logic [DATA_W-1:0] accum;
        flags_s flags;
        logic file_we;
        logic [ADDR_W-1:0] file_waddr;
        logic [DATA_W-1:0] file_wdata;
        logic no_operation;
        logic [DATA_W-1:0] pin_meta;
        logic [DATA_W-1:0] pin_sync;
    } exec_state_s;

endpackage : exec_pkg

// *** rtl/exec_alu.sv ***
`timescale 1ns/1ps
`default_nettype none

module exec_alu
    import exec_pkg::*;
(
    input wire op_e op_i,
    input wire logic [DATA_W-1:0] accum_i,
    input wire logic [DATA_W-1:0] operand_i,
    input wire logic [DATA_W-1:0] lit_i,
    input wire logic [BIT_W-1:0] bidx_i,
    output alu_out_s out_o
);

    // Operation unit: pure combinational, the caller picks flags to keep
    always_comb begin
        logic [DATA_W-1:0] rhs;
        logic [DATA_W:0] sum;
        logic [NIBBLE_W:0] low;
        logic [DATA_W-1:0] mask;
        rhs = operand_i;
        sum = '0;
        low = '0;
        mask = ONE_HOT_BIT0 << bidx_i;
        // Immediate forms take the literal instead of the file value
        if (op_i == OP_ADD_IMMEDIATE_TO_ACCUM ||
            op_i == OP_AND_IMMEDIATE_WITH_ACCUM) begin
            rhs = lit_i;
        end
        sum = {1'b0, accum_i} + {1'b0, rhs};
        low = {1'b0, accum_i[NIBBLE_W-1:0]} + {1'b0, rhs[NIBBLE_W-1:0]};
        out_o.bit_val = operand_i[bidx_i];
        out_o.flags.carry = sum[DATA_W];
        out_o.flags.half_carry_flag = low[NIBBLE_W];
        case (op_i)
            OP_ADD_IMMEDIATE_TO_ACCUM, OP_ADD_ACCUM_WITH_FILE: begin
                out_o.result = sum[DATA_W-1:0];
            end
            OP_AND_IMMEDIATE_WITH_ACCUM, OP_AND_ACCUM_WITH_FILE: begin
                out_o.result = accum_i & rhs;
            end
            OP_BIT_CLEAR_IN_FILE: begin
                out_o.result = operand_i & ~mask;
            end
            OP_BIT_SET_IN_FILE: begin
                out_o.result = operand_i | mask;
            end
            default: begin
                // Tests leave the file value untouched
                out_o.result = operand_i;
            end
        endcase
        out_o.flags.zero = (out_o.result == ZERO_BYTE);
    end

endmodule : exec_alu
`default_nettype wire

// *** sim/add_and_bit_ops_exec_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module add_and_bit_ops_exec_tb_top import exec_pkg::*;;
    logic clk_i; // 40 MHz core clock
    logic srst_i; // Synchronous reset
    instr_s instr_i; // Instruction offered to the slice
    logic [DATA_W-1:0] file_rdata_i; // File register latch value
    logic file_is_port_i; // Operand is an I/O port
    logic [DATA_W-1:0] pin_levels_i; // Raw pin levels
    logic instr_skip_o, no_operation_o, file_we_o; // Strobes
    logic [DATA_W-1:0] accum_o, file_wdata_o; // Data outputs
    logic [ADDR_W-1:0] file_waddr_o; // Write address
    flags_s flags_o; // Status flags
    int fails, n_compared, cycles; // Score and watchdog

    add_and_bit_ops_exec i_dut (.clk_i(clk_i), .srst_i(srst_i),
        .instr_i(instr_i), .file_rdata_i(file_rdata_i),
        .file_is_port_i(file_is_port_i), .pin_levels_i(pin_levels_i),
        .instr_skip_o(instr_skip_o), .no_operation_o(no_operation_o),
        .accum_o(accum_o), .flags_o(flags_o), .file_we_o(file_we_o),
        .file_waddr_o(file_waddr_o), .file_wdata_o(file_wdata_o));

    // Free running clock, 25 ns period
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Watchdog: the whole run needs well under a few hundred cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails++;
            tally_and_finish();
        end
    end

    // Verdict and end of run, the only exit
    task automatic tally_and_finish();
        if (fails == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // Case-equal compare so an unknown never counts as a match
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : chk

    // Offer one instruction at the falling edge; result shows one edge on
    task automatic iss(input op_e o, input logic [7:0] l,
                       input logic [6:0] a, input logic d,
                       input logic [2:0] b, input logic [7:0] f);
        instr_i = '{valid: 1'b1, op: o, lit: l, faddr: a, dest: d, bidx: b};
        file_rdata_i = f;
        @(negedge clk_i);
    endtask : iss

    // Drop valid for one cycle
    task automatic idle();
        instr_i.valid = 1'b0;
        @(negedge clk_i);
    endtask : idle

    // Accumulator and flags {carry, half carry, zero} together
    task automatic res(input logic [7:0] a, input logic [2:0] f);
        chk(accum_o, a, "accum");
        chk({5'h00, flags_o}, {5'h00, f}, "flags");
    endtask : res

    // File write strobe, address and data together
    task automatic wr(input logic we, input logic [6:0] a,
                      input logic [7:0] d);
        chk({7'h00, file_we_o}, {7'h00, we}, "write strobe");
        if (we) chk({1'b0, file_waddr_o}, {1'b0, a}, "write addr");
        if (we) chk(file_wdata_o, d, "write data");
    endtask : wr

    // Add forms, flags from bit 7 and bit 3 carries and zero result
    task automatic t_add();
        iss(OP_ADD_IMMEDIATE_TO_ACCUM, 8'h0F, 7'h00, DEST_FILE, 3'h0, 8'h00);
        res(8'h0F, 3'h0);
        iss(OP_ADD_IMMEDIATE_TO_ACCUM, 8'h01, 7'h00, DEST_ACCUM, 3'h0, 8'h00);
        res(8'h10, 3'h2);
        iss(OP_ADD_IMMEDIATE_TO_ACCUM, 8'hF0, 7'h00, DEST_ACCUM, 3'h0, 8'h00);
        res(8'h00, 3'h5);
        wr(1'b0, 7'h00, 8'h00);
        iss(OP_ADD_ACCUM_WITH_FILE, 8'h00, 7'h7F, DEST_FILE, 3'h0, 8'h88);
        res(8'h00, 3'h0);
        wr(1'b1, 7'h7F, 8'h88);
        iss(OP_ADD_ACCUM_WITH_FILE, 8'h00, 7'h7F, DEST_ACCUM, 3'h0, 8'h88);
        wr(1'b0, 7'h00, 8'h00);
        iss(OP_ADD_ACCUM_WITH_FILE, 8'h00, 7'h7F, DEST_ACCUM, 3'h0, 8'h88);
        res(8'h10, 3'h6);
    endtask : t_add

    // AND forms touch zero only, carry and half carry survive
    task automatic t_and();
        iss(OP_ADD_IMMEDIATE_TO_ACCUM, 8'hEE, 7'h00, DEST_ACCUM, 3'h0, 8'h00);
        res(8'hFE, 3'h0);
        iss(OP_ADD_IMMEDIATE_TO_ACCUM, 8'hFF, 7'h00, DEST_ACCUM, 3'h0, 8'h00);
        res(8'hFD, 3'h6);
        iss(OP_AND_IMMEDIATE_WITH_ACCUM, 8'h02, 7'h00, DEST_FILE, 3'h0,
            8'hFF);
        res(8'h00, 3'h7);
        iss(OP_ADD_IMMEDIATE_TO_ACCUM, 8'h3C, 7'h00, DEST_ACCUM, 3'h0, 8'h00);
        iss(OP_AND_ACCUM_WITH_FILE, 8'h00, 7'h05, DEST_FILE, 3'h0, 8'hF0);
        res(8'h3C, 3'h0);
        wr(1'b1, 7'h05, 8'h30);
        iss(OP_AND_ACCUM_WITH_FILE, 8'h00, 7'h05, DEST_ACCUM, 3'h0, 8'hC3);
        res(8'h00, 3'h1);
        wr(1'b0, 7'h00, 8'h00);
    endtask : t_and

    // Every bit index cleared and set back to back, flags left alone
    task automatic t_bits();
        iss(OP_ADD_IMMEDIATE_TO_ACCUM, 8'h81, 7'h00, DEST_ACCUM, 3'h0, 8'h00);
        for (int b = 0; b < 8; b++) begin
            iss(OP_BIT_CLEAR_IN_FILE, 8'h00, 7'h12, DEST_ACCUM, b[2:0], 8'hFF);
            wr(1'b1, 7'h12, 8'hFF ^ (8'h01 << b));
            res(8'h81, 3'h0);
            iss(OP_BIT_SET_IN_FILE, 8'h00, 7'h12, DEST_ACCUM, b[2:0], 8'h00);
            wr(1'b1, 7'h12, 8'h01 << b);
            res(8'h81, 3'h0);
        end
    endtask : t_bits

    // Taken skips drop the next offer; untaken ones let it run
    task automatic t_skip();
        for (int b = 0; b < 8; b++) begin
            iss(OP_TEST_BIT_SKIP_IF_ZERO, 8'h00, 7'h20, DEST_ACCUM, b[2:0],
                8'hFF ^ (8'h01 << b));
            // Discard slot first, idle slot flag follows one cycle later
            chk({6'h00, instr_skip_o, no_operation_o}, 8'h02, "skip");
            iss(OP_ADD_IMMEDIATE_TO_ACCUM, 8'h01, 7'h00, DEST_ACCUM, 3'h0,
                8'h00);
            chk({6'h00, instr_skip_o, no_operation_o}, 8'h01, "skip end");
            res(8'h81, 3'h0);
            iss(OP_TEST_BIT_SKIP_IF_ONE, 8'h00, 7'h20, DEST_ACCUM, b[2:0],
                8'h01 << b);
            chk({6'h00, instr_skip_o, no_operation_o}, 8'h02, "skip");
            iss(OP_BIT_SET_IN_FILE, 8'h00, 7'h20, DEST_ACCUM, 3'h0, 8'h00);
            wr(1'b0, 7'h00, 8'h00);
            chk({6'h00, instr_skip_o, no_operation_o}, 8'h01, "nop slot");
        end
        iss(OP_TEST_BIT_SKIP_IF_ZERO, 8'h00, 7'h20, DEST_ACCUM, 3'h7, 8'h80);
        chk({7'h00, instr_skip_o}, 8'h00, "no skip");
        iss(OP_TEST_BIT_SKIP_IF_ONE, 8'h00, 7'h20, DEST_ACCUM, 3'h7, 8'h7F);
        chk({7'h00, instr_skip_o}, 8'h00, "no skip");
        res(8'h81, 3'h0);
        iss(OP_ADD_IMMEDIATE_TO_ACCUM, 8'h01, 7'h00, DEST_ACCUM, 3'h0, 8'h00);
        res(8'h82, 3'h0);
    endtask : t_skip

    // Port operand comes from the pins, latch value differs on purpose
    task automatic t_port();
        file_is_port_i = 1'b1;
        pin_levels_i = 8'h5A;
        repeat (3) idle();
        iss(OP_ADD_ACCUM_WITH_FILE, 8'h00, 7'h06, DEST_FILE, 3'h0, 8'h00);
        wr(1'b1, 7'h06, 8'hDC);
        idle();
        file_is_port_i = 1'b0;
    endtask : t_port

    // Main sequence
    initial begin
        fails = 0;
        n_compared = 0;
        cycles = 0;
        srst_i = 1'b1;
        instr_i = '0;
        file_rdata_i = 8'h00;
        file_is_port_i = 1'b0;
        pin_levels_i = 8'h00;
        // Count rising edges: the clock's first step from unknown to low
        // would otherwise pass for a falling edge and shorten the reset
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        srst_i = 1'b0;
        res(ACCUM_RST, 3'h0);
        wr(1'b0, 7'h00, 8'h00);
        t_add();
        t_and();
        t_bits();
        t_skip();
        t_port();
        tally_and_finish();
    end
endmodule : add_and_bit_ops_exec_tb_top

`default_nettype wire
